// ---- verilog/psac_pkg.sv ----
/*
  Constants for the host-side controller of an asynchronous pseudo-static RAM.
  Assumes a single 25 MHz core clock; all pin timing is derived from it here.
*/
package psac_pkg;

  // Clock period in nanoseconds
  localparam int CLK_PERIOD_NS = 40;

  // Pin and timer widths
  localparam int ADDR_W  = 22;
  localparam int DATA_W  = 16;
  localparam int TIMER_W = 18;

  // Least read and write cycle, least write strobe width (ns)
  localparam int READ_CYCLE_MIN_NS   = 70;
  localparam int WRITE_CYCLE_MIN_NS  = 70;
  localparam int WRITE_PULSE_MIN_NS  = 50;
  // Power-keep select hold after power on (us)
  localparam int POWERUP_SELECT_HOLD_US = 30;
  // Least deep power-down pulse (ms) and hold after exit (us)
  localparam int POWERDOWN_PULSE_MIN_MS = 10;
  localparam int POWERDOWN_EXIT_HOLD_US = 300;

  // Cycle counts: least times round up
  localparam int READ_CYCLES  = (READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_CYCLES = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Setup + strobe + recovery must cover the write cycle
  localparam int WRITE_CYCLES = (WRITE_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_CYCLES =
    (POWERUP_SELECT_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PD_PULSE_CYCLES =
    (POWERDOWN_PULSE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXIT_HOLD_CYCLES =
    (POWERDOWN_EXIT_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Controller states
  typedef enum logic [3:0] {
    ST_BOOT   = 4'h0,
    ST_PWRUP  = 4'h1,
    ST_IDLE   = 4'h2,
    ST_READ   = 4'h3,
    ST_WSETUP = 4'h4,
    ST_WPULSE = 4'h5,
    ST_WREC   = 4'h6,
    ST_PD     = 4'h7,
    ST_EXIT   = 4'h8
  } psac_state_e;

endpackage : psac_pkg

// ---- verilog/psac_timer.sv ----
/*
  Loadable down-counter used for every wait of the controller.
  Assumes the loader issues a load only when it wants a fresh interval.
*/
`timescale 1ns/100ps
module psac_timer (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Load request
  input  wire logic                        load,
  input  wire logic [psac_pkg::TIMER_W-1:0] loadValue,
  // Expiry
  output logic                             done
);

  logic [psac_pkg::TIMER_W-1:0] count;      // Remaining cycles
  logic [psac_pkg::TIMER_W-1:0] next_count; // Next remaining count

  // Load wins; otherwise count down and stop at zero
  always_comb begin
    if (load) begin
      next_count = loadValue;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end else begin
      next_count = count;
    end
  end

  // Register the counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Expired once the count has reached zero; a load in the same cycle shows next cycle
  assign done = (count == '0);

endmodule : psac_timer

// ---- verilog/psac_host.sv ----
/*
  Host controller driving an asynchronous pseudo-static RAM over its pins:
  power-up hold, single-word reads and writes, deep power-down entry and exit.
  Assumes a user port that holds a request until taken and pins synchronous
  to core_clk.
*/
`timescale 1ns/100ps
module psac_host #(
  parameter int PD_PULSE_CYCLES  = psac_pkg::PD_PULSE_CYCLES,
  parameter int EXIT_HOLD_CYCLES = psac_pkg::EXIT_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // User request
  input  wire logic                        reqValid,
  input  wire logic                        reqWrite,
  input  wire logic [psac_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [psac_pkg::DATA_W-1:0] reqData,
  input  wire logic [1:0]                  reqByteEn,
  output logic                             reqReady,
  // User answer
  output logic                             respValid,
  output logic [psac_pkg::DATA_W-1:0]      respData,
  // Power control and status
  input  wire logic                        pdReq,
  input  wire logic                        lostClear,
  output logic                             pdActive,
  output logic                             contentsLost,
  // Memory pins
  output logic [psac_pkg::ADDR_W-1:0]      memAddr,
  output logic                             primary_select_n,
  output logic                             power_keep_select,
  output logic                             lower_byte_select_n,
  output logic                             upper_byte_select_n,
  output logic                             writeStrobeN,
  output logic                             outputEnableN,
  output logic [psac_pkg::DATA_W-1:0]      dataOut,
  output logic                             dataOe,
  input  wire logic [psac_pkg::DATA_W-1:0] dataIn
);

  psac_pkg::psac_state_e state, next_state;   // Sequencer state
  logic                        next_reqReady;  // Ready for a new request
  logic                        next_respValid; // Read answer strobe
  logic [psac_pkg::DATA_W-1:0] next_respData;  // Captured read word
  logic                        next_pdActive;  // Power-down status
  logic                        next_lost;      // Contents lost flag
  logic [psac_pkg::ADDR_W-1:0] next_memAddr;   // Address pins
  logic                        next_cs;        // Primary select
  logic                        next_keep;      // Power-keep select
  logic                        next_lb;        // Lower byte select
  logic                        next_ub;        // Upper byte select
  logic                        next_we;        // Write strobe
  logic                        next_oe;        // Output enable
  logic [psac_pkg::DATA_W-1:0] next_dataOut;   // Write data
  logic                        next_dataOe;    // Data drive enable
  logic                        tLoad;          // Timer load
  logic [psac_pkg::TIMER_W-1:0] tValue;        // Timer load value
  logic                        tDone;          // Timer expired

  // Shared interval timer
  psac_timer u_timer (
    .core_clk  (core_clk),
    .rst       (rst),
    .load      (tLoad),
    .loadValue (tValue),
    .done      (tDone)
  );

  // Sequencer: computes every next pin and status value
  always_comb begin
    next_state     = state;
    next_respValid = 1'b0;
    next_respData  = respData;
    next_memAddr   = memAddr;
    next_cs        = primary_select_n;
    next_keep      = power_keep_select;
    next_lb        = lower_byte_select_n;
    next_ub        = upper_byte_select_n;
    next_we        = writeStrobeN;
    next_oe        = outputEnableN;
    next_dataOut   = dataOut;
    next_dataOe    = dataOe;
    next_lost      = contentsLost & ~lostClear;
    tLoad          = 1'b0;
    tValue         = '0;
    unique case (state)
      // Start the power-up hold with power-keep high
      psac_pkg::ST_BOOT: begin
        tLoad      = 1'b1;
        tValue     = psac_pkg::TIMER_W'(psac_pkg::POWERUP_CYCLES - 1);
        next_state = psac_pkg::ST_PWRUP;
      end
      // No access until the hold has run out
      psac_pkg::ST_PWRUP: begin
        if (tDone) begin
          next_state = psac_pkg::ST_IDLE;
        end
      end
      // Power-down takes priority over a waiting access
      psac_pkg::ST_IDLE: begin
        if (pdReq) begin
          next_keep  = 1'b0;
          tLoad      = 1'b1;
          tValue     = psac_pkg::TIMER_W'(PD_PULSE_CYCLES - 1);
          next_state = psac_pkg::ST_PD;
        end else if (reqValid) begin
          next_memAddr = reqAddr;
          next_cs      = 1'b0; // Select falls before the strobe
          next_lb      = ~reqByteEn[0];
          next_ub      = ~reqByteEn[1];
          if (reqWrite) begin
            // Output enable already high, so memory is released
            next_dataOut = reqData;
            next_dataOe  = 1'b1;
            next_state   = psac_pkg::ST_WSETUP;
          end else begin
            next_oe    = 1'b0;
            tLoad      = 1'b1;
            tValue     = psac_pkg::TIMER_W'(psac_pkg::READ_CYCLES - 1);
            next_state = psac_pkg::ST_READ;
          end
        end
      end
      // Hold a full-length read, then capture and release
      psac_pkg::ST_READ: begin
        if (tDone) begin
          next_respData  = dataIn;
          next_respValid = 1'b1;
          next_cs        = 1'b1;
          next_oe        = 1'b1;
          next_lb        = 1'b1;
          next_ub        = 1'b1;
          next_state     = psac_pkg::ST_IDLE;
        end
      end
      // One setup cycle, then the strobe falls
      psac_pkg::ST_WSETUP: begin
        next_we    = 1'b0;
        tLoad      = 1'b1;
        tValue     = psac_pkg::TIMER_W'(psac_pkg::WPULSE_CYCLES - 1);
        next_state = psac_pkg::ST_WPULSE;
      end
      // Strobe rises while selects are still low
      psac_pkg::ST_WPULSE: begin
        if (tDone) begin
          next_we    = 1'b1;
          next_state = psac_pkg::ST_WREC;
        end
      end
      // Release selects and data one cycle after the strobe
      psac_pkg::ST_WREC: begin
        next_cs     = 1'b1;
        next_lb     = 1'b1;
        next_ub     = 1'b1;
        next_dataOe = 1'b0;
        next_state  = psac_pkg::ST_IDLE;
      end
      // Keep power-keep low for the least pulse and while asked
      psac_pkg::ST_PD: begin
        if (tDone && !pdReq) begin
          next_keep  = 1'b1;
          tLoad      = 1'b1;
          tValue     = psac_pkg::TIMER_W'(EXIT_HOLD_CYCLES - 1);
          next_state = psac_pkg::ST_EXIT;
        end
      end
      // Wait out the exit hold before any access
      psac_pkg::ST_EXIT: begin
        if (tDone) begin
          next_state = psac_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = psac_pkg::ST_BOOT;
      end
    endcase
    // Entering power-down destroys contents; set wins over clear
    if (state == psac_pkg::ST_PD) begin
      next_lost = 1'b1;
    end
    next_reqReady = (next_state == psac_pkg::ST_IDLE) && !tLoad;
    next_pdActive = (next_state == psac_pkg::ST_PD) || (next_state == psac_pkg::ST_EXIT);
  end

  // Register state and all pins; everything but power-keep idles deselected
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state               <= psac_pkg::ST_BOOT;
      reqReady            <= 1'b0;
      respValid           <= 1'b0;
      respData            <= '0;
      pdActive            <= 1'b0;
      contentsLost        <= 1'b0;
      memAddr             <= '0;
      primary_select_n    <= 1'b1;
      power_keep_select   <= 1'b1;
      lower_byte_select_n <= 1'b1;
      upper_byte_select_n <= 1'b1;
      writeStrobeN        <= 1'b1;
      outputEnableN       <= 1'b1;
      dataOut             <= '0;
      dataOe              <= 1'b0;
    end else begin
      state               <= next_state;
      reqReady            <= next_reqReady;
      respValid           <= next_respValid;
      respData            <= next_respData;
      pdActive            <= next_pdActive;
      contentsLost        <= next_lost;
      memAddr             <= next_memAddr;
      primary_select_n    <= next_cs;
      power_keep_select   <= next_keep;
      lower_byte_select_n <= next_lb;
      upper_byte_select_n <= next_ub;
      writeStrobeN        <= next_we;
      outputEnableN       <= next_oe;
      dataOut             <= next_dataOut;
      dataOe              <= next_dataOe;
    end
  end

  // Helper counters for the checks below
  logic [17:0] keepHighCnt; // Cycles with power-keep high, saturating
  logic [17:0] keepLowCnt;  // Cycles with power-keep low, saturating
  logic        keepDropped; // Power-keep has been low since reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      keepHighCnt <= '0;
      keepLowCnt  <= '0;
      keepDropped <= 1'b0;
    end else begin
      keepDropped <= keepDropped | ~power_keep_select;
      keepHighCnt <= !power_keep_select ? '0 : (&keepHighCnt ? keepHighCnt : keepHighCnt + 1'b1);
      keepLowCnt  <= power_keep_select ? '0 : (&keepLowCnt ? keepLowCnt : keepLowCnt + 1'b1);
    end
  end

  property p_read_len;
    @(posedge core_clk) disable iff (rst)
      ($fell(primary_select_n) && !outputEnableN) |-> !primary_select_n [*2];
  endproperty
  a_read_len: assert property (p_read_len) else $error("read cycle too short");

  property p_write_len;
    @(posedge core_clk) disable iff (rst)
      $fell(writeStrobeN) |-> (!writeStrobeN && !primary_select_n) [*2]
        ##1 (writeStrobeN && !primary_select_n);
  endproperty
  a_write_len: assert property (p_write_len) else $error("write strobe shape wrong");

  property p_write_oe;
    @(posedge core_clk) disable iff (rst)
      !writeStrobeN |-> outputEnableN && dataOe && $past(!primary_select_n);
  endproperty
  a_write_oe: assert property (p_write_oe) else $error("write without release");

  property p_no_fight;
    @(posedge core_clk) disable iff (rst)
      dataOe |-> outputEnableN && $past(outputEnableN);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("data driven against memory");

  // After a power-down only the exit hold applies, not the power-on hold
  property p_powerup;
    @(posedge core_clk) disable iff (rst)
      $fell(primary_select_n) |->
        keepHighCnt >= (keepDropped ? 18'(EXIT_HOLD_CYCLES) : 18'(psac_pkg::POWERUP_CYCLES));
  endproperty
  a_powerup: assert property (p_powerup) else $error("access before select hold");

  property p_pd_pulse;
    @(posedge core_clk) disable iff (rst)
      $rose(power_keep_select) |-> $past(keepLowCnt) >= 18'(PD_PULSE_CYCLES - 1);
  endproperty
  a_pd_pulse: assert property (p_pd_pulse) else $error("power-down pulse too short");

  property p_lost;
    @(posedge core_clk) disable iff (rst)
      $fell(power_keep_select) |-> ##2 contentsLost;
  endproperty
  a_lost: assert property (p_lost) else $error("loss flag not set");

endmodule : psac_host

// ---- test/psac_mem_model.sv ----
/*
  Behavioural pseudo-static RAM die seen by the host controller.
  Assumes registered host pins and no pull on the data lines.
*/
`timescale 1ns/100ps
module psac_mem_model #(
  parameter int PD_MIN_NS    = 800,
  parameter int EXIT_MIN_NS  = 400,
  parameter int PWRUP_MIN_NS = 30000,
  parameter int CYCLE_MIN_NS = 70
) (
  // Host pins
  input  wire logic [21:0] memAddr,
  input  wire logic        primary_select_n,
  input  wire logic        power_keep_select,
  input  wire logic        lower_byte_select_n,
  input  wire logic        upper_byte_select_n,
  input  wire logic        writeStrobeN,
  input  wire logic        outputEnableN,
  input  wire logic [15:0] dataOut,
  input  wire logic        dataOe,
  // Data back to host
  output logic [15:0]      memData,
  output logic             memDrive,
  // Count of protocol faults seen
  output int               faultCount
);
  logic [15:0] store [0:255];  // Small window of the array
  logic [15:0] lastOut;        // Last driven word
  realtime     upTime;         // Power-keep select last rose
  realtime     downTime;       // Power-keep select last fell
  realtime     selTime;        // Primary select last fell
  logic        pdSeen;         // A power-down has happened
  wire         sel = !primary_select_n && power_keep_select;

  initial begin
    faultCount = 0;
    lastOut    = 16'h5A5A;
    upTime     = 0;
    downTime   = -1.0e12;
    selTime    = -1.0e12;
    pdSeen     = 1'b0;
  end

  // Drive only in a read shape: write strobe high and output enable low
  always_comb memDrive = sel && !outputEnableN && writeStrobeN &&
                         !(lower_byte_select_n && upper_byte_select_n);
  // Released lines show the inverse so a stale value cannot pass
  always_comb memData = memDrive ? store[memAddr[7:0]] : ~lastOut;
  always @(posedge memDrive) #1 lastOut = memData;

  // Store on the rising write strobe, per byte lane
  always @(posedge writeStrobeN) begin
    if (sel && !lower_byte_select_n) store[memAddr[7:0]][7:0] = dataOe ? dataOut[7:0] : 8'hXX;
    if (sel && !upper_byte_select_n) store[memAddr[7:0]][15:8] = dataOe ? dataOut[15:8] : 8'hXX;
  end

  // Deep power-down wipes the array
  always @(negedge power_keep_select) begin
    downTime = $realtime;
    pdSeen   = 1'b1;
    foreach (store[i]) store[i] = 16'hXXXX;
  end
  // Too short a power-down pulse is a fault
  always @(posedge power_keep_select) begin
    if ($realtime - downTime < PD_MIN_NS) faultCount++;
    upTime = $realtime;
  end
  // Access too early after power on or after exit
  always @(negedge primary_select_n) begin
    selTime = $realtime;
    if ($realtime - upTime < (pdSeen ? EXIT_MIN_NS : PWRUP_MIN_NS)) faultCount++;
  end
  // Short select cycles are faults
  always @(posedge primary_select_n)
    if ($realtime - selTime < CYCLE_MIN_NS) faultCount++;
  // Both parties driving the data lines
  always @(dataOe or memDrive) #1 if (dataOe && memDrive) faultCount++;
  // Output enable low under a write strobe
  always @(negedge writeStrobeN) #1 if (!outputEnableN) faultCount++;
endmodule : psac_mem_model

// ---- test/test_psac_host.sv ----
/*
  Self-checking bench for the host controller with a pseudo-static RAM model.
  Assumes the controller parameters are shortened for power-down timing.
*/
`timescale 1ns/100ps
module test_psac_host;
  localparam int PD_CYC   = 20;
  localparam int EXIT_CYC = 10;

  logic                        core_clk, rst, reqValid, reqWrite, pdReq, lostClear;
  logic [psac_pkg::ADDR_W-1:0] reqAddr, memAddr;
  logic [psac_pkg::DATA_W-1:0] reqData, respData, dataOut, dataIn;
  logic [1:0]                  reqByteEn;
  logic                        reqReady, respValid, pdActive, contentsLost, dataOe, memDrive;
  logic                        primary_select_n, power_keep_select, writeStrobeN, outputEnableN;
  logic                        lower_byte_select_n, upper_byte_select_n;
  int                          faultCount, fail_count, n_checks;

  psac_host #(.PD_PULSE_CYCLES(PD_CYC), .EXIT_HOLD_CYCLES(EXIT_CYC)) uut (
    .core_clk(core_clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqData(reqData), .reqByteEn(reqByteEn), .reqReady(reqReady),
    .respValid(respValid), .respData(respData), .pdReq(pdReq), .lostClear(lostClear),
    .pdActive(pdActive), .contentsLost(contentsLost), .memAddr(memAddr),
    .primary_select_n(primary_select_n), .power_keep_select(power_keep_select),
    .lower_byte_select_n(lower_byte_select_n), .upper_byte_select_n(upper_byte_select_n),
    .writeStrobeN(writeStrobeN), .outputEnableN(outputEnableN), .dataOut(dataOut),
    .dataOe(dataOe), .dataIn(dataIn));

  psac_mem_model #(.PD_MIN_NS(PD_CYC * 40), .EXIT_MIN_NS(EXIT_CYC * 40)) mem (
    .memAddr(memAddr), .primary_select_n(primary_select_n),
    .power_keep_select(power_keep_select), .lower_byte_select_n(lower_byte_select_n),
    .upper_byte_select_n(upper_byte_select_n), .writeStrobeN(writeStrobeN),
    .outputEnableN(outputEnableN), .dataOut(dataOut), .dataOe(dataOe),
    .memData(dataIn), .memDrive(memDrive), .faultCount(faultCount));

  // Clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // One request; returns read word and edges from take to answer
  task automatic do_req(input logic wr, input logic [21:0] a, input logic [15:0] d,
                        input logic [1:0] be, output logic [15:0] rd, output int lat);
    int n;
    @(negedge core_clk);
    reqValid = 1'b1; reqWrite = wr; reqAddr = a; reqData = d; reqByteEn = be;
    n = 0;
    do begin @(posedge core_clk); n++; end while (reqReady !== 1'b1 && n < 2000);
    check_bit(reqReady, 1'b1, "request taken");
    @(negedge core_clk);
    reqValid = 1'b0;
    lat = 0;
    rd  = 16'hXXXX;
    // Reads only: respValid pulse is seen in its own cycle
    while (!wr && lat < 20) begin
      @(posedge core_clk); #1; lat++;
      if (respValid === 1'b1) begin rd = respData; break; end
    end
  endtask : do_req

  // Reset values, then the power-on hold
  task automatic t_reset;
    int n;
    check_bit(power_keep_select, 1'b1, "keep select in reset");
    check_bit(primary_select_n, 1'b1, "select in reset");
    check_bit(dataOe, 1'b0, "data drive in reset");
    @(negedge core_clk); rst = 1'b0;
    n = 0;
    while (reqReady !== 1'b1 && n < 3000) begin @(posedge core_clk); #1; n++; end
    check_bit(n >= psac_pkg::POWERUP_CYCLES && n < 3000, 1'b1, "power-on hold length");
  endtask : t_reset

  // Back-to-back writes with every byte enable, reads with both bytes enabled
  task automatic t_rw;
    logic [15:0] rd;
    int          lat;
    do_req(1'b1, 22'h000005, 16'hAAAA, 2'h3, rd, lat);
    do_req(1'b1, 22'h000006, 16'h5555, 2'h3, rd, lat);
    do_req(1'b0, 22'h000005, 16'h0000, 2'h3, rd, lat);
    check_word(32'(rd), 32'h0000AAAA, "read word");
    check_word(32'(lat), 32'(psac_pkg::READ_CYCLES), "read latency");
    do_req(1'b1, 22'h000005, 16'h1234, 2'h1, rd, lat);
    do_req(1'b1, 22'h000005, 16'h99FF, 2'h2, rd, lat);
    do_req(1'b1, 22'h000005, 16'hFFFF, 2'h0, rd, lat);
    do_req(1'b0, 22'h000005, 16'h0000, 2'h3, rd, lat);
    check_word(32'(rd), 32'h00009934, "byte lanes");
    do_req(1'b0, 22'h000006, 16'h0000, 2'h3, rd, lat);
    check_word(32'(rd), 32'h00005555, "second word");
  endtask : t_rw

  // Deep power-down with a short request, exit hold, lost flag
  task automatic t_pd;
    int          lowN, holdN;
    logic [15:0] rd;
    int          lat;
    @(negedge core_clk); pdReq = 1'b1;
    @(posedge core_clk); #1;
    check_bit(power_keep_select, 1'b0, "keep select low");
    check_bit(pdActive, 1'b1, "power-down active");
    @(posedge core_clk); #1;
    check_bit(contentsLost, 1'b1, "contents lost");
    @(negedge core_clk); pdReq = 1'b0;
    // One edge has passed since the fall; count the rest up to the rise
    lowN = 1;
    while (power_keep_select !== 1'b1 && lowN < 500) begin @(posedge core_clk); #1; lowN++; end
    check_word(32'(lowN), 32'(PD_CYC), "power-down pulse");
    holdN = 0;
    while (reqReady !== 1'b1 && holdN < 500) begin @(posedge core_clk); #1; holdN++; end
    check_word(32'(holdN), 32'(EXIT_CYC), "exit hold");
    check_bit(pdActive, 1'b0, "power-down over");
    check_bit(contentsLost, 1'b1, "lost stays");
    @(negedge core_clk); lostClear = 1'b1;
    @(negedge core_clk); lostClear = 1'b0;
    check_bit(contentsLost, 1'b0, "lost cleared");
    do_req(1'b1, 22'h000007, 16'hC3C3, 2'h3, rd, lat);
    do_req(1'b0, 22'h000007, 16'h0000, 2'h3, rd, lat);
    check_word(32'(rd), 32'h0000C3C3, "after exit");
  endtask : t_pd

  // Main sequence
  initial begin
    fail_count = 0; n_checks = 0;
    rst = 1'b1; reqValid = 1'b0; reqWrite = 1'b0; reqAddr = '0; reqData = '0;
    reqByteEn = 2'h0; pdReq = 1'b0; lostClear = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    t_reset();
    t_rw();
    t_pd();
    repeat (4) @(posedge core_clk);
    check_word(32'(faultCount), 32'h0, "pin protocol faults");
    report_and_stop();
  end

  // Watchdog: whole run is under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end
endmodule : test_psac_host
